// File: rtl/cisc_pkg.sv
package cisc_pkg;

  // ---------------------------------------------------------------
  // slave address
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_MASK = 7'h79;
  localparam logic [6:0] ADDR_BASE = 7'h30;
  localparam int         ADDR_SEL_LSB = 1;

  // ---------------------------------------------------------------
  // internal memory map (pointer values)
  // ---------------------------------------------------------------
  localparam logic [7:0] PTR_CTRL = 8'h00;
  localparam logic [7:0] PTR_XH   = 8'h01;
  localparam logic [7:0] PTR_XL   = 8'h02;
  localparam logic [7:0] PTR_YH   = 8'h03;
  localparam logic [7:0] PTR_YL   = 8'h04;
  localparam logic [7:0] PTR_RST  = 8'h00;

  // ---------------------------------------------------------------
  // measure_strap_control fields
  // ---------------------------------------------------------------
  localparam int         CTRL_TM    = 0;
  localparam int         CTRL_FWD   = 1;
  localparam int         CTRL_REV   = 2;
  localparam logic [7:0] CTRL_WMASK = 8'h07;
  localparam logic [7:0] CTRL_RST   = 8'h00;

  // ---------------------------------------------------------------
  // result format
  // ---------------------------------------------------------------
  localparam int         RES_W    = 12;
  localparam logic [3:0] RES_FILL = 4'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_AACK  = 7'h04,
    ST_WBYTE = 7'h08,
    ST_WACK  = 7'h10,
    ST_RBYTE = 7'h20,
    ST_RACK  = 7'h40
  } cisc_state_t;

  typedef struct packed {
    logic rev;
    logic fwd;
    logic tm;
  } cisc_cmd_t;

  typedef struct packed {
    logic [RES_W-1:0] x;
    logic [RES_W-1:0] y;
  } cisc_axes_t;

endpackage

// File: rtl/cisc_sync.sv
`timescale 1ns/1ns
module cisc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // the first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// File: rtl/cisc_slave.sv
`timescale 1ns/1ns
module cisc_slave
  import cisc_pkg::*;
#(
  parameter logic [1:0] ADDR_SEL = 2'h0
) (
  // system
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  // two-wire bus pins
  input  wire logic             SCL_I,
  input  wire logic             SDA_I,
  output logic                  SDA_O,
  output logic                  SDA_OE,
  // sensor side, clocked by SENSE_CLK
  input  wire logic             SENSE_CLK,
  output logic                  MEAS_START,
  output logic                  STRAP_FWD,
  output logic                  STRAP_REV,
  input  wire logic             MEASUREMENT_DONE,
  input  wire logic [RES_W-1:0] MEAS_X,
  input  wire logic [RES_W-1:0] MEAS_Y,
  input  wire logic             STRAP_PULSE_DONE
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic addr_match(input logic [6:0] a);
    addr_match = ((a & ADDR_MASK) == ADDR_BASE) &&
                 (a[ADDR_SEL_LSB +: 2] == ADDR_SEL);
  endfunction

  function automatic logic [7:0] ctrl_wval(input logic [7:0] b);
    logic [7:0] v;
    v = b & CTRL_WMASK;
    if (v[CTRL_FWD]) begin
      v[CTRL_REV] = 1'b0;
    end
    ctrl_wval = v;
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] p,
                                          input logic [7:0] c,
                                          input cisc_axes_t r);
    if (p == PTR_CTRL) begin
      read_mux = c & CTRL_WMASK;
    end else if (p == PTR_XH) begin
      read_mux = {RES_FILL, r.x[RES_W-1:8]};
    end else if (p == PTR_XL) begin
      read_mux = r.x[7:0];
    end else if (p == PTR_YH) begin
      read_mux = {RES_FILL, r.y[RES_W-1:8]};
    end else if (p == PTR_YL) begin
      read_mux = r.y[7:0];
    end else begin
      read_mux = 8'h00;
    end
  endfunction

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_p_q;
  logic        sda_p_q;

  // pins pass inverted so the cleared stages mean an idle high bus,
  // otherwise reset release would fake a falling clock edge
  cisc_sync #(.W(2)) u_pin_sync (
    .clk (REF_CLK),
    .rst (RST),
    .d   ({~SCL_I, ~SDA_I}),
    .q   (pins_s)
  );

  assign scl_s = ~pins_s[1];
  assign sda_s = ~pins_s[0];

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;

  // start and stop seen only while the clock stays high; rise and fall from the clock alone
  assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_c  = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign rise_c  = scl_s && !scl_p_q;
  assign fall_c  = !scl_s && scl_p_q;

  // ---------------------------------------------------------------
  // protocol engine
  // ---------------------------------------------------------------
  cisc_state_t state_q;
  logic [2:0]  bit_q;
  logic [7:0]  sh_q;
  logic        sda_oe_q;
  logic        rw_q;
  logic        ack_on_q;
  logic        more_q;
  logic        first_q;
  logic [7:0]  ptr_q;
  logic [7:0]  ctrl_q;
  cisc_axes_t  axes_q;
  logic [7:0]  rx_byte;
  logic [7:0]  rd_data;
  logic        rx_done;
  logic        wr_byte_ev;
  logic        ptr_wr;
  logic        ctrl_wr;
  logic        rd_load;

  assign rx_byte    = {sh_q[6:0], sda_s};
  assign rx_done    = rise_c && (bit_q == BIT_LAST);
  assign wr_byte_ev = (state_q == ST_WBYTE) && rx_done;
  assign ptr_wr     = wr_byte_ev && first_q;
  assign ctrl_wr    = wr_byte_ev && !first_q && (ptr_q == PTR_CTRL);
  assign rd_data    = read_mux(ptr_q, ctrl_q, axes_q);
  assign rd_load    = fall_c &&
                      (((state_q == ST_AACK) && ack_on_q && rw_q) ||
                       ((state_q == ST_RACK) && more_q));

  // outputs change only on a sampled falling clock, except that a start or stop releases the line
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_q  <= ST_IDLE;
      bit_q    <= 3'h0;
      sh_q     <= 8'h00;
      sda_oe_q <= 1'b0;
      rw_q     <= 1'b0;
      ack_on_q <= 1'b0;
      more_q   <= 1'b0;
      first_q  <= 1'b0;
    end else if (stop_c) begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start_c) begin
      state_q  <= ST_ADDR;
      bit_q    <= 3'h0;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (rise_c) begin
            sh_q  <= rx_byte;
            bit_q <= bit_q + 3'h1;
            if (bit_q == BIT_LAST) begin
              if (addr_match(rx_byte[7:1])) begin
                state_q  <= ST_AACK;
                rw_q     <= rx_byte[0];
                ack_on_q <= 1'b0;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
        end
        ST_AACK: begin
          if (fall_c && !ack_on_q) begin
            ack_on_q <= 1'b1;
            sda_oe_q <= 1'b1;
          end else if (fall_c) begin
            ack_on_q <= 1'b0;
            bit_q    <= 3'h0;
            if (rw_q) begin
              sh_q     <= rd_data;
              sda_oe_q <= !rd_data[7];
              state_q  <= ST_RBYTE;
            end else begin
              sda_oe_q <= 1'b0;
              first_q  <= 1'b1;
              state_q  <= ST_WBYTE;
            end
          end
        end
        ST_WBYTE: begin
          if (rise_c) begin
            sh_q  <= rx_byte;
            bit_q <= bit_q + 3'h1;
            if (bit_q == BIT_LAST) begin
              state_q  <= ST_WACK;
              ack_on_q <= 1'b0;
            end
          end
        end
        ST_WACK: begin
          if (fall_c && !ack_on_q) begin
            ack_on_q <= 1'b1;
            sda_oe_q <= 1'b1;
          end else if (fall_c) begin
            ack_on_q <= 1'b0;
            sda_oe_q <= 1'b0;
            bit_q    <= 3'h0;
            first_q  <= 1'b0;
            state_q  <= ST_WBYTE;
          end
        end
        ST_RBYTE: begin
          if (fall_c) begin
            sh_q     <= {sh_q[6:0], 1'b0};
            sda_oe_q <= !sh_q[6];
          end else if (rise_c) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == BIT_LAST) begin
              state_q <= ST_RACK;
              more_q  <= 1'b0;
            end
          end
        end
        ST_RACK: begin
          if (fall_c && !more_q) begin
            sda_oe_q <= 1'b0;
          end else if (rise_c) begin
            if (sda_s) begin
              state_q <= ST_IDLE;
            end else begin
              more_q <= 1'b1;
            end
          end else if (fall_c) begin
            sh_q     <= rd_data;
            sda_oe_q <= !rd_data[7];
            bit_q    <= 3'h0;
            more_q   <= 1'b0;
            state_q  <= ST_RBYTE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // open drain: only ever pulls low, never drives a start
  assign SDA_O  = 1'b0;
  assign SDA_OE = sda_oe_q;

  // ---------------------------------------------------------------
  // memory pointer
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ptr_q <= PTR_RST;
    end else if (ptr_wr) begin
      ptr_q <= rx_byte;
    end else if (rd_load || (wr_byte_ev && !first_q)) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // crossings from the sensor domain
  // ---------------------------------------------------------------
  logic       mdone_tgl_q;
  logic       sdone_tgl_q;
  cisc_axes_t axes_hold_q;
  logic [1:0] done_s;
  logic [1:0] done_p_q;
  logic       mdone_ev;
  logic       sdone_ev;

  cisc_sync #(.W(2)) u_done_sync (
    .clk (REF_CLK),
    .rst (RST),
    .d   ({mdone_tgl_q, sdone_tgl_q}),
    .q   (done_s)
  );

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      done_p_q <= 2'h0;
    end else begin
      done_p_q <= done_s;
    end
  end

  assign mdone_ev = done_s[1] ^ done_p_q[1];
  assign sdone_ev = done_s[0] ^ done_p_q[0];

  // hold register is stable for several edges after each toggle
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      axes_q <= '0;
    end else if (mdone_ev) begin
      axes_q <= axes_hold_q;
    end
  end

  // ---------------------------------------------------------------
  // measure_strap_control register
  // ---------------------------------------------------------------
  logic [7:0] wval;
  assign wval = ctrl_wval(rx_byte);

  // a write landing with a done event wins over the clear
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= wval;
    end else begin
      if (mdone_ev) begin
        ctrl_q[CTRL_TM] <= 1'b0;
      end
      if (sdone_ev) begin
        ctrl_q[CTRL_FWD] <= 1'b0;
        ctrl_q[CTRL_REV] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // command crossing to the sensor domain
  // ---------------------------------------------------------------
  cisc_cmd_t cmd_q;
  logic      cmd_tgl_q;

  // command word stays put until the next toggle is issued
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cmd_q     <= '0;
      cmd_tgl_q <= 1'b0;
    end else if (ctrl_wr && (wval != 8'h00)) begin
      cmd_q.tm  <= wval[CTRL_TM];
      cmd_q.fwd <= wval[CTRL_FWD];
      cmd_q.rev <= wval[CTRL_REV];
      cmd_tgl_q <= !cmd_tgl_q;
    end
  end

  // ---------------------------------------------------------------
  // sensor domain
  // ---------------------------------------------------------------
  logic cmd_s;
  logic cmd_p_q;

  cisc_sync #(.W(1)) u_cmd_sync (
    .clk (SENSE_CLK),
    .rst (RST),
    .d   (cmd_tgl_q),
    .q   (cmd_s)
  );

  always_ff @(posedge SENSE_CLK or posedge RST) begin
    if (RST) begin
      cmd_p_q    <= 1'b0;
      MEAS_START <= 1'b0;
      STRAP_FWD  <= 1'b0;
      STRAP_REV  <= 1'b0;
    end else begin
      cmd_p_q    <= cmd_s;
      MEAS_START <= (cmd_s ^ cmd_p_q) && cmd_q.tm;
      STRAP_FWD  <= (cmd_s ^ cmd_p_q) && cmd_q.fwd;
      STRAP_REV  <= (cmd_s ^ cmd_p_q) && cmd_q.rev;
    end
  end

  always_ff @(posedge SENSE_CLK or posedge RST) begin
    if (RST) begin
      mdone_tgl_q <= 1'b0;
      sdone_tgl_q <= 1'b0;
      axes_hold_q <= '0;
    end else begin
      if (MEASUREMENT_DONE) begin
        axes_hold_q <= '{x: MEAS_X, y: MEAS_Y};
        mdone_tgl_q <= !mdone_tgl_q;
      end
      if (STRAP_PULSE_DONE) begin
        sdone_tgl_q <= !sdone_tgl_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_ADDR_MISS: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_q == ST_ADDR && rx_done && !start_c && !stop_c &&
     !addr_match(rx_byte[7:1])) |=> state_q == ST_IDLE)
    else $error("foreign address not ignored");
  AST_DIR: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_q == ST_ADDR && rx_done && !start_c && !stop_c &&
     addr_match(rx_byte[7:1])) |=> rw_q == $past(sda_s))
    else $error("direction bit not latched");
  AST_ACK: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_q == ST_AACK && fall_c && !ack_on_q && !stop_c && !start_c)
      |=> SDA_OE ##1 SDA_OE)
    else $error("address not acknowledged");
  AST_NINE: assert property (@(posedge REF_CLK) disable iff (RST)
    (wr_byte_ev && !start_c && !stop_c) |=> state_q == ST_WACK)
    else $error("eighth bit did not end the byte");
  AST_STABLE: assert property (@(posedge REF_CLK) disable iff (RST)
    ($changed(sda_oe_q) && !$past(start_c) && !$past(stop_c)) |-> !scl_s)
    else $error("data moved while clock high");
  AST_START: assert property (@(posedge REF_CLK) disable iff (RST)
    start_c && !stop_c |=> state_q == ST_ADDR && bit_q == 3'h0 && !SDA_OE)
    else $error("start not taken");
  AST_SLAVE: assert property (@(posedge REF_CLK) disable iff (RST)
    SDA_OE |-> state_q != ST_IDLE && state_q != ST_ADDR)
    else $error("line driven outside a called transfer");
  AST_TM_CLR: assert property (@(posedge REF_CLK) disable iff (RST)
    (mdone_ev && !ctrl_wr) |=> !ctrl_q[CTRL_TM] &&
      axes_q == $past(axes_hold_q))
    else $error("measurement bit not cleared with results");
  AST_STRAP_CLR: assert property (@(posedge REF_CLK)
    disable iff (RST)
    (sdone_ev && !ctrl_wr) |=> !ctrl_q[CTRL_FWD] && !ctrl_q[CTRL_REV])
    else $error("strap bits not cleared");
  AST_NACK: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_q == ST_RACK && rise_c && sda_s && !start_c && !stop_c)
      |=> state_q == ST_IDLE ##1 !SDA_OE)
    else $error("byte sent after no acknowledge");
  AST_FILL: assert property (@(posedge REF_CLK) disable iff (RST)
    (rd_load && (ptr_q == PTR_XH || ptr_q == PTR_YH) && !start_c && !stop_c)
      |=> sh_q[7:4] == RES_FILL)
    else $error("upper axis bits not zero");
  AST_PTR: assert property (@(posedge REF_CLK) disable iff (RST)
    rd_load |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance");
  AST_FWD_WIN: assert property (@(posedge REF_CLK) disable iff (RST)
    (ctrl_wr && rx_byte[CTRL_FWD] && rx_byte[CTRL_REV])
      |=> ctrl_q[CTRL_FWD] && !ctrl_q[CTRL_REV])
    else $error("reverse kept alongside forward");
  AST_RSVD: assert property (@(posedge REF_CLK) disable iff (RST)
    (ctrl_q & ~CTRL_WMASK) == 8'h00)
    else $error("reserved control bit set");
  AST_RES_FIRST: assert property (@(posedge REF_CLK)
    disable iff (RST)
    ($fell(ctrl_q[CTRL_TM]) && !$past(ctrl_wr)) |-> $past(mdone_ev))
    else $error("measurement bit cleared without results");

endmodule

// File: verif/cisc_bus_master.sv
`timescale 1ns/1ns
module cisc_bus_master (
  // clock
  input  wire logic        clk,
  // bus lines, sda_in is the resolved wire
  input  wire logic        sda_in,
  output logic             scl,
  output logic             sda,
  // outcome of each byte, one-cycle strobe
  output logic [15:0]      res,
  output logic             res_stb
);
  // --------------------------------------------------------------
  // bit timing in clk cycles: scl low 1.3 us, high 0.7 us
  // --------------------------------------------------------------
  localparam int TL = 130;
  localparam int TH = 70;

  initial begin
    scl = 1'b1;
    sda = 1'b1;
    res = 16'h0000;
    res_stb = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic put(input logic [15:0] v);
    res = v;
    res_stb = 1'b1;
    tick(1);
    res_stb = 1'b0;
  endtask

  // sda is raised first so a repeated start also begins on a free bus
  task automatic start();
    sda = 1'b1;
    tick(TL / 2);
    scl = 1'b1;
    tick(TH);
    sda = 1'b0;
    tick(TH);
    scl = 1'b0;
    tick(TL / 2);
  endtask

  task automatic stop();
    sda = 1'b0;
    tick(TL / 2);
    scl = 1'b1;
    tick(TH);
    sda = 1'b1;
    tick(TH);
  endtask

  task automatic bit_io(input logic b, output logic s);
    sda = b;
    tick(TL / 2);
    scl = 1'b1;
    tick(TH / 2);
    s = sda_in;
    tick(TH / 2);
    scl = 1'b0;
    tick(TL / 2);
  endtask

  task automatic wbyte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    put(16'hA000 | 16'(!s));
  endtask

  task automatic rbyte(input logic ack);
    logic [7:0] d;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!ack, s);
    put({8'hD0, d});
  endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import cisc_pkg::*;

  localparam logic [1:0] SEL  = 2'h2;
  localparam logic [6:0] ADDR = {4'h6, SEL, 1'h0};

  logic             ref_clk;
  logic             rst;
  logic             sense_clk;
  logic             scl;
  logic             sda_m;
  wire              sda_bus;
  logic             sda_o;
  logic             sda_oe;
  logic             meas_start;
  logic             strap_fwd;
  logic             strap_rev;
  logic             mdone;
  logic             sdone;
  logic [RES_W-1:0] mx;
  logic [RES_W-1:0] my;
  logic [15:0]      res;
  logic             res_stb;
  logic [15:0]      q [$];
  logic [7:0]       mem [5];
  logic [31:0]      seed;
  logic             scl_q;
  logic             oe_q;
  int               mismatches;
  int               tests_run;
  logic [6:0]       probe [6] = '{7'h30, 7'h32, 7'h34, 7'h36, 7'h74, 7'h35};

  // open-drain data wire with pull-up
  assign sda_bus = sda_m & (sda_o | ~sda_oe);

  cisc_slave #(.ADDR_SEL(SEL)) cisc_slave_i (
    .REF_CLK(ref_clk), .RST(rst), .SCL_I(scl), .SDA_I(sda_bus),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .SENSE_CLK(sense_clk),
    .MEAS_START(meas_start), .STRAP_FWD(strap_fwd),
    .STRAP_REV(strap_rev), .MEASUREMENT_DONE(mdone), .MEAS_X(mx),
    .MEAS_Y(my), .STRAP_PULSE_DONE(sdone));

  cisc_bus_master cisc_bus_master_i (
    .clk(ref_clk), .sda_in(sda_bus), .scl(scl), .sda(sda_m),
    .res(res), .res_stb(res_stb));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // 15 ns link clock, offset so only its falling edges miss ref_clk's; its rising edges land on ref_clk edges
  initial begin
    sense_clk = 1'b0;
    #3;
    forever begin
      #7 sense_clk = 1'b1;
      #8 sense_clk = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // checking
  // --------------------------------------------------------------
  task automatic take(input string what, input logic [15:0] got);
    logic [15:0] e;
    e = (q.size() != 0) ? q.pop_front() : 16'hFFFF;
    tests_run++;
    if (got !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask

  always @(posedge ref_clk) begin
    if (res_stb === 1'b1) take("bus byte", res);
    if (!rst && scl && scl_q && sda_oe !== oe_q) begin
      mismatches++;
      $display("CHECK FAILED sda_oe expected %b seen %b", oe_q, sda_oe);
    end
    scl_q <= scl;
    oe_q <= sda_oe;
  end

  always @(posedge sense_clk) begin
    if (meas_start === 1'b1) take("command", 16'hC001);
    if (strap_fwd === 1'b1) take("command", 16'hC002);
    if (strap_rev === 1'b1) take("command", 16'hC004);
  end

  task automatic tally_and_finish();
    if (q.size() != 0) mismatches++;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end

  // --------------------------------------------------------------
  // stimulus
  // --------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic send(input logic [7:0] b, input logic a);
    q.push_back(16'hA000 | 16'(a));
    cisc_bus_master_i.wbyte(b);
  endtask

  task automatic write_ctrl(input logic [7:0] v);
    logic [7:0] w;
    w = v & 8'h07;
    if (w[1]) w[2] = 1'b0;
    cisc_bus_master_i.start();
    send({ADDR, 1'h0}, 1'b1);
    send(8'h00, 1'b1);
    for (int i = 0; i < 3; i++) begin
      if (w[i]) q.push_back(16'hC000 | (16'h1 << i));
    end
    send(v, 1'b1);
    cisc_bus_master_i.stop();
    mem[0] = w;
  endtask

  task automatic read_from(input logic [7:0] p, input int n,
                           input logic setp);
    if (setp) begin
      cisc_bus_master_i.start();
      send({ADDR, 1'h0}, 1'b1);
      send(p, 1'b1);
    end
    cisc_bus_master_i.start();
    send({ADDR, 1'h1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      q.push_back({8'hD0, mem[p + i]});
      cisc_bus_master_i.rbyte(i < n - 1);
    end
    cisc_bus_master_i.stop();
  endtask

  task automatic sense(input logic meas);
    @(posedge sense_clk);
    #1;
    seed = xs(seed);
    mx = seed[11:0];
    my = seed[27:16];
    mdone = meas;
    sdone = !meas;
    @(posedge sense_clk);
    #1;
    mdone = 1'b0;
    sdone = 1'b0;
    if (meas) begin
      mem[0][0] = 1'b0;
      mem[1] = {4'h0, seed[11:8]};
      mem[2] = seed[7:0];
      mem[3] = {4'h0, seed[27:24]};
      mem[4] = seed[23:16];
    end else begin
      mem[0][2:1] = 2'h0;
    end
    repeat (10) @(posedge ref_clk);
    #1;
  endtask

  initial begin
    rst = 1'b1;
    mdone = 1'b0;
    sdone = 1'b0;
    mx = 12'h000;
    my = 12'h000;
    seed = 32'hE088;
    mismatches = 0;
    tests_run = 0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    read_from(8'h00, 2, 1'b0);
    $display("test reset_state done");
    foreach (probe[i]) begin
      cisc_bus_master_i.start();
      send({probe[i], 1'h0}, probe[i] == ADDR);
      cisc_bus_master_i.stop();
    end
    $display("test addressing done");
    write_ctrl(8'hFF);
    read_from(8'h00, 1, 1'b1);
    $display("test control_write done");
    sense(1'b0);
    sense(1'b1);
    read_from(8'h00, 5, 1'b1);
    $display("test measurement done");
    write_ctrl(8'h04);
    sense(1'b0);
    read_from(8'h00, 1, 1'b1);
    $display("test reverse_strap done");
    // leave a pending measurement and a moved pointer, then reset
    write_ctrl(8'h01);
    rst = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    read_from(8'h00, 2, 1'b0);
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule
